// ===== hw/ctc_clk_if.sv
`timescale 1ns/100ps
interface ctc_clk_if;
  ctc_pkg::ctc_src_t src_sel;
  logic              ext_fall;
  logic              tick;
  modport sync  (output ext_fall);
  modport presc (input src_sel, input ext_fall, output tick);
  modport core  (output src_sel, input ext_fall, input tick);
endinterface

// ===== hw/ctc_pkg.sv
package ctc_pkg;

  // ----------------------------------------------------------------
  // bus and register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  localparam logic [7:0] OFS_CTL_LO = 8'h00;  // lower_counter_control
  localparam logic [7:0] OFS_CTL_HI = 8'h04;  // upper_counter_control
  localparam logic [7:0] OFS_PER_LO = 8'h08;  // period_compare_low
  localparam logic [7:0] OFS_PER_HI = 8'h0C;  // period_compare_high
  localparam logic [7:0] OFS_PW_LO  = 8'h10;  // width_compare_low
  localparam logic [7:0] OFS_PW_HI  = 8'h14;  // width_compare_high
  localparam logic [7:0] OFS_CNT_LO = 8'h18;  // live count, low byte
  localparam logic [7:0] OFS_CNT_HI = 8'h1C;  // live count, high byte

  // ----------------------------------------------------------------
  // control fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SRC_LSB  = 0;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned RUN_BIT  = 3;  // counter_run_bit
  localparam int unsigned FFI_BIT  = 7;  // flipflop_initial_bit
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam int unsigned PSC_W    = 11;

  typedef enum logic [1:0] {
    CTC_EVENT = 2'b00,
    CTC_PWM   = 2'b01,
    CTC_PPG   = 2'b10
  } ctc_mode_t;

  typedef enum logic [2:0] {
    SRC_DIV2048 = 3'b000,
    SRC_DIV128  = 3'b001,
    SRC_DIV32   = 3'b010,
    SRC_DIV8    = 3'b011,
    SRC_DIV2    = 3'b100,
    SRC_FULL    = 3'b101,
    SRC_EXT     = 3'b110
  } ctc_src_t;

endpackage

// ===== hw/ctc_presc.sv
`timescale 1ns/100ps
module ctc_presc (
  // clock and reset
  input  logic hclk,
  input  logic hresetn,
  // select in, tick out
  ctc_clk_if.presc cif
);
  import ctc_pkg::*;

  logic [PSC_W-1:0] psc_q;
  logic             tick_q;
  logic             hit;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psc_q <= '0;
    end else begin
      psc_q <= psc_q + {{(PSC_W-1){1'b0}}, 1'b1};
    end
  end

  always_comb begin
    unique case (cif.src_sel)
      SRC_DIV2048: hit = &psc_q[10:0];
      SRC_DIV128:  hit = &psc_q[6:0];
      SRC_DIV32:   hit = &psc_q[4:0];
      SRC_DIV8:    hit = &psc_q[2:0];
      SRC_DIV2:    hit = psc_q[0];
      SRC_FULL:    hit = 1'b1;
      default:     hit = cif.ext_fall;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= hit;
    end
  end

  assign cif.tick = tick_q;

endmodule

// ===== hw/ctc_sync.sv
`timescale 1ns/100ps
module ctc_sync (
  // clock and reset
  input  logic hclk,
  input  logic hresetn,
  // pin
  input  logic event_input_pin,
  // edge out
  ctc_clk_if.sync cif
);
  import ctc_pkg::*;

  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic fall_q;

  // ----------------------------------------------------------------
  // two-stage synchroniser, then falling-edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= event_input_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // pulses narrower than one clock may be lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_q <= 1'b0;
    end else begin
      fall_q <= prev_q & ~sync_q;
    end
  end

  assign cif.ext_fall = fall_q;

  property p_fall;
    @(posedge hclk) disable iff (!hresetn)
      (prev_q && !sync_q) |=> fall_q;
  endproperty
  a_fall: assert property (p_fall)
    else $error("falling edge not flagged");

endmodule

// ===== hw/ctc_top.sv
`timescale 1ns/100ps
module ctc_top (
  // clock and reset
  input  logic                         hclk,
  input  logic                         hresetn,
  // ahb-lite slave
  input  logic                         hsel,
  input  logic [ctc_pkg::ADDR_W-1:0]   haddr,
  input  logic [1:0]                   htrans,
  input  logic                         hwrite,
  input  logic [2:0]                   hsize,
  input  logic [ctc_pkg::DATA_W-1:0]   hwdata,
  input  logic                         hready,
  output logic [ctc_pkg::DATA_W-1:0]   hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // pins
  input  logic                         event_input_pin,
  output logic                         width_mod_out_pin,
  output logic                         pulse_gen_out_pin,
  output logic                         match_interrupt
);
  import ctc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]  ctl_lo_q;
  logic [7:0]  ctl_hi_q;
  logic [7:0]  per_lo_q;
  logic [7:0]  per_hi_q;
  logic [15:0] pw_wr_q;
  logic [15:0] pw_act_q;
  logic [7:0]  cnt_lo_q;
  logic [7:0]  cnt_hi_q;
  logic        ff_q;
  logic        irq_q;
  logic        pwm_pin_q;
  logic        ppg_pin_q;
  logic [7:0]  adr_q;
  logic        hit_q;
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;

  ctc_mode_t   mode;
  logic        run;
  logic        ap_ok;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_plo;
  logic        wr_phi;
  logic        wr_wlo;
  logic        wr_whi;
  logic [7:0]  wbyte;
  logic [15:0] cnt;
  logic [15:0] nxt;
  logic [15:0] per;
  logic [15:0] pw_cmp;
  logic        tick_en;
  logic        step;
  logic        per_hit;
  logic        pw_hit;
  logic        ovf;
  logic        clr;
  logic        flip;
  logic [7:0]  rd8;

  ctc_clk_if cif ();

  ctc_sync u_sync (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .event_input_pin (event_input_pin),
    .cif             (cif)
  );

  ctc_presc u_presc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cif     (cif)
  );

  assign cif.src_sel = ctc_src_t'(ctl_lo_q[SRC_LSB +: 3]);

  // ----------------------------------------------------------------
  // ahb-lite slave: writes zero-wait, reads one wait state
  // ----------------------------------------------------------------
  assign ap_ok = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adr_q     <= 8'h00;
      hit_q     <= 1'b0;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= ap_ok & hwrite;
      rd_pend_q <= ap_ok & ~hwrite;
      if (ap_ok) begin
        adr_q <= haddr[7:0];
        hit_q <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h00000000;
      hresp_q     <= 1'b0;
    end else begin
      if (ap_ok && !hwrite) begin
        hreadyout_q <= 1'b0;
      end else if (rd_pend_q) begin
        hreadyout_q <= 1'b1;
        hrdata_q    <= {24'h000000, rd8};
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;

  assign wbyte  = hwdata[7:0];
  assign wr_lo  = wr_pend_q && hit_q && (adr_q == OFS_CTL_LO);
  assign wr_hi  = wr_pend_q && hit_q && (adr_q == OFS_CTL_HI);
  assign wr_plo = wr_pend_q && hit_q && (adr_q == OFS_PER_LO);
  assign wr_phi = wr_pend_q && hit_q && (adr_q == OFS_PER_HI);
  assign wr_wlo = wr_pend_q && hit_q && (adr_q == OFS_PW_LO);
  assign wr_whi = wr_pend_q && hit_q && (adr_q == OFS_PW_HI);

  always_comb begin
    rd8 = 8'h00;
    if (hit_q) begin
      unique case (adr_q)
        OFS_CTL_LO: rd8 = ctl_lo_q;
        OFS_CTL_HI: rd8 = ctl_hi_q;
        OFS_PER_LO: rd8 = per_lo_q;
        OFS_PER_HI: rd8 = per_hi_q;
        OFS_PW_LO:  rd8 = (mode == CTC_PWM && run) ? pw_act_q[7:0] : pw_wr_q[7:0];
        OFS_PW_HI:  rd8 = (mode == CTC_PWM && run) ? pw_act_q[15:8] : pw_wr_q[15:8];
        OFS_CNT_LO: rd8 = cnt_lo_q;
        OFS_CNT_HI: rd8 = cnt_hi_q;
        default:    rd8 = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control and compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_lo_q <= RST_BYTE;
      ctl_hi_q <= RST_BYTE;
    end else begin
      if (wr_lo) ctl_lo_q <= wbyte;
      if (wr_hi) ctl_hi_q <= wbyte;
    end
  end

  // period is unbuffered: a write takes effect on the next count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_lo_q <= RST_BYTE;
      per_hi_q <= RST_BYTE;
      pw_wr_q  <= {RST_BYTE, RST_BYTE};
    end else begin
      if (wr_plo) per_lo_q <= wbyte;
      if (wr_phi) per_hi_q <= wbyte;
      if (wr_wlo) pw_wr_q[7:0] <= wbyte;
      if (wr_whi) pw_wr_q[15:8] <= wbyte;
    end
  end

  // shift stage feeding the active width compare in pwm mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pw_act_q <= {RST_BYTE, RST_BYTE};
    end else if (!run || (mode == CTC_PWM && clr)) begin
      pw_act_q <= pw_wr_q;
    end
  end

  // ----------------------------------------------------------------
  // cascaded counter and match logic
  // ----------------------------------------------------------------
  assign mode    = ctc_mode_t'(ctl_hi_q[MODE_LSB +: 2]);
  assign run     = ctl_hi_q[RUN_BIT];
  assign cnt     = {cnt_hi_q, cnt_lo_q};
  assign nxt     = cnt + 16'h0001;
  assign per     = {per_hi_q, per_lo_q};
  assign pw_cmp  = (mode == CTC_PWM) ? pw_act_q : pw_wr_q;
  assign tick_en = (mode == CTC_EVENT) ? cif.ext_fall : cif.tick;
  assign step    = run & tick_en;
  assign per_hit = (nxt == per);
  assign pw_hit  = (nxt == pw_cmp);
  assign ovf     = (cnt == 16'hFFFF);

  always_comb begin
    clr  = 1'b0;
    flip = 1'b0;
    unique case (mode)
      CTC_EVENT: begin
        clr = step & per_hit;
      end
      CTC_PWM: begin
        clr  = step & ovf;
        flip = step & (ovf | pw_hit);
      end
      CTC_PPG: begin
        clr  = step & per_hit;
        flip = step & (per_hit | pw_hit);
      end
      default: begin
        clr  = 1'b0;
        flip = 1'b0;
      end
    endcase
  end

  // 16-bit count built from two byte counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_lo_q <= 8'h00;
      cnt_hi_q <= 8'h00;
    end else if (!run || clr) begin
      cnt_lo_q <= 8'h00;
      cnt_hi_q <= 8'h00;
    end else if (step) begin
      cnt_lo_q <= cnt_lo_q + 8'h01;
      if (&cnt_lo_q) cnt_hi_q <= cnt_hi_q + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= clr;
    end
  end

  // ----------------------------------------------------------------
  // output flip-flop and pins
  // ----------------------------------------------------------------
  // the stopping write itself never reloads the level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ff_q <= 1'b0;
    end else if (wr_hi && !run) begin
      ff_q <= wbyte[FFI_BIT];
    end else if (flip) begin
      ff_q <= ~ff_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_pin_q <= 1'b1;
      ppg_pin_q <= 1'b1;
    end else begin
      pwm_pin_q <= ~ff_q;
      ppg_pin_q <= ~ff_q;
    end
  end

  assign width_mod_out_pin = pwm_pin_q;
  assign pulse_gen_out_pin = ppg_pin_q;
  assign match_interrupt   = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_evt_inc;
    (mode == CTC_EVENT && step && !per_hit) |=> (cnt == $past(nxt));
  endproperty
  a_evt_inc: assert property (p_evt_inc)
    else $error("event count did not advance by one");

  property p_evt_match;
    (mode == CTC_EVENT && step && per_hit) |=> (cnt == 16'h0000) && match_interrupt;
  endproperty
  a_evt_match: assert property (p_evt_match)
    else $error("event period match not handled");

  property p_carry;
    (step && !clr && run && cnt_lo_q == 8'hFF) |=>
      (cnt_lo_q == 8'h00) && (cnt_hi_q == $past(cnt_hi_q) + 8'h01);
  endproperty
  a_carry: assert property (p_carry)
    else $error("low byte wrap did not carry");

  property p_wide;
    (mode == CTC_PWM && step && cnt == 16'h00FF) |=> (cnt == 16'h0100);
  endproperty
  a_wide: assert property (p_wide)
    else $error("counter not 16 bits wide");

  property p_pwm_ovf;
    (mode == CTC_PWM && step && ovf) |=>
      (cnt == 16'h0000) && match_interrupt && (ff_q != $past(ff_q));
  endproperty
  a_pwm_ovf: assert property (p_pwm_ovf)
    else $error("pwm overflow not handled");

  property p_pwm_width;
    (mode == CTC_PWM && step && !ovf && pw_hit && !wr_hi) |=>
      (ff_q != $past(ff_q)) && (cnt != 16'h0000) && !match_interrupt;
  endproperty
  a_pwm_width: assert property (p_pwm_width)
    else $error("pwm width match not handled");

  property p_ppg_per;
    (mode == CTC_PPG && step && per_hit && !wr_hi) |=>
      (cnt == 16'h0000) && match_interrupt && (ff_q != $past(ff_q));
  endproperty
  a_ppg_per: assert property (p_ppg_per)
    else $error("pulse period match not handled");

  property p_pin;
    ##1 1'b1 |-> (width_mod_out_pin == !$past(ff_q)) && (pulse_gen_out_pin == !$past(ff_q));
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin not inverse of flip-flop");

  property p_ffinit;
    (wr_hi && !run) |=> (ff_q == $past(wbyte[FFI_BIT]));
  endproperty
  a_ffinit: assert property (p_ffinit)
    else $error("flip-flop did not load initial bit");

  property p_hold;
    ($fell(run) && !wr_hi) |=> $stable(ff_q) ##1 $stable(width_mod_out_pin);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output moved after stop");

  property p_pw_buf;
    (mode == CTC_PWM && run && !clr) |=> $stable(pw_act_q);
  endproperty
  a_pw_buf: assert property (p_pw_buf)
    else $error("pwm width changed between matches");

  property p_rd_pw;
    (rd_pend_q && hit_q && adr_q == OFS_PW_LO && mode == CTC_PWM && run) |=>
      (hrdata == {24'h000000, $past(pw_act_q[7:0])}) && hreadyout;
  endproperty
  a_rd_pw: assert property (p_rd_pw)
    else $error("pwm width read not from shift stage");

  property p_per_wr;
    wr_plo |=> (per_lo_q == $past(wbyte)) && (per[7:0] == $past(wbyte));
  endproperty
  a_per_wr: assert property (p_per_wr)
    else $error("period write not immediate");

  property p_ppg_pw;
    (mode == CTC_PPG && wr_wlo && !wr_hi) |=> (pw_cmp[7:0] == $past(wbyte));
  endproperty
  a_ppg_pw: assert property (p_ppg_pw)
    else $error("pulse width write not immediate");

endmodule

// ===== verification/cascaded_16bit_timer_modes_bench.sv
`timescale 1ns/100ps
module cascaded_16bit_timer_modes_bench;
  import ctc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int TIMEOUT = 90000;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        event_input_pin, width_mod_out_pin, pulse_gen_out_pin;
  logic        match_interrupt, go, done;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  half;
  logic [15:0] pulses;
  int          num_errors, comparisons, cyc, irq_cnt, last_irq, irq_gap;
  int          low_run, last_low, i0;
  int unsigned n, k, w, p, w2;
  logic        pin_hold;

  assign hready = hreadyout;

  ctc_top i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .event_input_pin(event_input_pin), .width_mod_out_pin(width_mod_out_pin),
    .pulse_gen_out_pin(pulse_gen_out_pin), .match_interrupt(match_interrupt));

  ctc_pulse_src i_src (
    .hclk(hclk), .go(go), .half(half), .pulses(pulses),
    .event_input_pin(event_input_pin), .done(done));

  always #50 hclk = ~hclk;

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic bus_cycle(input logic [7:0] a, input logic wr, input logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    bus_cycle(a, 1'b1, d);
  endtask

  task automatic bus_read(input logic [7:0] a);
    bus_cycle(a, 1'b0, 8'h00);
  endtask

  task automatic set16(input logic [7:0] a_lo, input logic [15:0] v);
    bus_write(a_lo, v[7:0]);
    bus_write(a_lo + 8'h04, v[15:8]);
  endtask

  task automatic events(input logic [7:0] h, input logic [15:0] cnt);
    half   <= h;
    pulses <= cnt;
    go     <= 1'b1;
    do @(posedge hclk); while (done !== 1'b1);
    go <= 1'b0;
    // edge flag lands within 4 cycles, count one edge later
    repeat (8) @(posedge hclk);
  endtask

  task automatic wait_irq(input int cnt);
    i0 = irq_cnt + cnt;
    while (irq_cnt < i0) @(posedge hclk);
    @(posedge hclk);
  endtask

  function automatic logic [31:0] exp_low(input int unsigned top, input int unsigned wd);
    return top - wd;
  endfunction

  function automatic logic [31:0] exp_count(input int unsigned kk, input int unsigned nn);
    return kk % nn;
  endfunction

  // ----------------------------------------------------------------
  // monitor: interrupt spacing, pin low time, timeout
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    cyc++;
    if (match_interrupt === 1'b1) begin
      irq_gap  = cyc - last_irq;
      last_irq = cyc;
      irq_cnt++;
    end
    if (width_mod_out_pin === 1'b0) begin
      low_run++;
    end else if (low_run > 0) begin
      last_low = low_run;
      low_run  = 0;
    end
    if (hresetn === 1'b1 && pulse_gen_out_pin !== width_mod_out_pin) begin
      check({31'h0, pulse_gen_out_pin}, {31'h0, width_mod_out_pin});
    end
    if (cyc == TIMEOUT) begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'b010; hwdata = 0; go = 0; half = 8'h02; pulses = 16'h0000;
    n = $urandom(45189);
    repeat (4) @(posedge hclk);
    check({30'h0, width_mod_out_pin, match_interrupt}, 32'h0000_0002);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus_read(OFS_PER_LO);
    check(rd, {24'h0, RST_BYTE});
    bus_write(8'h40, 8'h5A);
    bus_read(8'h20);
    check(rd, 32'h0000_0000);
    // event mode, 16-bit count across the byte boundary
    bus_write(OFS_CTL_LO, 8'h06);
    bus_write(OFS_CTL_HI, 8'h00);
    set16(OFS_PER_LO, 16'h0102);
    bus_write(OFS_CTL_HI, 8'h08);
    events(8'h02, 16'h0101);
    bus_read(OFS_CNT_LO);
    check(rd, 32'h0000_0001);
    bus_read(OFS_CNT_HI);
    check(rd, 32'h0000_0001);
    check(irq_cnt, 32'h0000_0000);
    events(8'h02, 16'h0003);
    bus_read(OFS_CNT_LO);
    check(rd, 32'h0000_0002);
    check(irq_cnt, 32'h0000_0001);
    // random periods and pulse rates
    repeat (3) begin
      n = 2 + $urandom % 8;
      k = 10 + $urandom % 21;
      bus_write(OFS_CTL_HI, 8'h00);
      set16(OFS_PER_LO, n[15:0]);
      bus_write(OFS_CTL_HI, 8'h08);
      i0 = irq_cnt;
      events(8'h02 + 8'($urandom % 4), k[15:0]);
      bus_read(OFS_CNT_LO);
      check(rd, exp_count(k, n));
      check(irq_cnt - i0, k / n);
    end
    // pulse generator mode
    bus_write(OFS_CTL_HI, 8'h00);
    p = 20 + $urandom % 41;
    w = 5 + $urandom % (p - 10);
    bus_write(OFS_CTL_LO, 8'h05);
    set16(OFS_PER_LO, p[15:0]);
    set16(OFS_PW_LO, w[15:0]);
    bus_write(OFS_CTL_HI, 8'h02);
    bus_write(OFS_CTL_HI, 8'h0A);
    wait_irq(3);
    check(irq_gap, p);
    check(last_low, exp_low(p, w));
    bus_write(OFS_CTL_HI, 8'h02);
    // the stopping edge may still flip the flip-flop; pins follow one edge later
    repeat (2) @(posedge hclk);
    pin_hold = width_mod_out_pin;
    repeat (4) @(posedge hclk);
    check({31'h0, width_mod_out_pin}, {31'h0, pin_hold});
    bus_write(OFS_CTL_HI, 8'h82);
    repeat (2) @(posedge hclk);
    check({31'h0, pulse_gen_out_pin}, 32'h0000_0000);
    bus_write(OFS_CTL_HI, 8'h02);
    repeat (2) @(posedge hclk);
    check({31'h0, width_mod_out_pin}, 32'h0000_0001);
    // width modulation mode, one full overflow period
    w  = 100 + $urandom % 60000;
    w2 = 100 + $urandom % 60000;
    bus_write(OFS_CTL_HI, 8'h01);
    set16(OFS_PW_LO, w[15:0]);
    bus_read(OFS_PW_LO);
    check(rd, {24'h0, w[7:0]});
    bus_write(OFS_CTL_HI, 8'h09);
    set16(OFS_PW_LO, w2[15:0]);
    bus_read(OFS_PW_HI);
    check(rd, {24'h0, w[15:8]});
    bus_read(OFS_PW_LO);
    check(rd, {24'h0, w[7:0]});
    wait_irq(1);
    check(last_low, exp_low(32'h0001_0000, w));
    bus_read(OFS_PW_HI);
    check(rd, {24'h0, w2[15:8]});
    check({31'h0, hresp}, 32'h0000_0000);
    bus_write(OFS_CTL_HI, 8'h01);
    conclude();
  end
endmodule

// ===== verification/ctc_pulse_src.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// outside pulse source for the event input pin
// ----------------------------------------------------------------
module ctc_pulse_src (
  // clock
  input  wire logic        hclk,
  // control from the bench
  input  wire logic        go,
  input  wire logic [7:0]  half,
  input  wire logic [15:0] pulses,
  // pin side
  output logic             event_input_pin,
  output logic             done
);
  logic [15:0] falls;
  logic [7:0]  t;

  // each level stands half cycles, half never below 2
  always @(posedge hclk) begin
    if (!go) begin
      falls           <= 16'h0000;
      t               <= 8'h00;
      done            <= 1'b0;
      event_input_pin <= 1'b1;
    end else if (!done) begin
      if (t == half - 8'h01) begin
        t <= 8'h00;
        if (event_input_pin && falls == pulses) begin
          done <= 1'b1;
        end else begin
          event_input_pin <= ~event_input_pin;
          if (event_input_pin) begin
            falls <= falls + 16'h0001;
          end
        end
      end else begin
        t <= t + 8'h01;
      end
    end
  end
endmodule
